//--- design/atr_cmd_top.sv
// Command interpreter for the analog tuning register access
`timescale 1ns/1ps
module atr_cmd_top
	import atr_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_byte,
	input wire logic rsp_ready,
	input wire logic protocol_choose_command,
	input wire logic [2:0] protocol_code,
	output logic [7:0] reader_analog_tuning,
	output logic [7:0] card_emulation_analog_tuning,
	output logic [6:0] modulation_pct,
	output logic [5:0] rx_gain_db,
	output logic [6:0] demod_sens_pct,
	output logic [3:0] load_mod_index
);
	atr_state_e state_reg;
	atr_state_e state_next;
	logic [7:0] len_reg;
	logic [7:0] remain_reg;
	logic is_write_reg;
	logic frame_ok_reg;
	logic inc_reg;
	logic [7:0] index_reg;
	logic [7:0] rsp1_reg;
	logic rsp_second_reg;
	logic [7:0] rsp_out_reg;
	logic take;
	logic give;
	logic last_rsp;
	logic is_write_code;
	logic is_read_code;
	logic len_ok;
	logic addr_ok;
	logic flag_ok;
	logic data_write;
	logic wr_reader;
	logic wr_card;
	logic load_reader;
	logic load_card;
	logic [7:0] reader_def;
	logic [7:0] indexed_value;
	logic [7:0] remain_dec;
	logic [7:0] index_inc;
	logic [7:0] len_now;
	logic len_bad;
	logic bad_len_write;
	logic code_ok;
	logic read_tail_ok;
	logic byte_ok;
	logic frame_ok_now;
	logic reply_start;
	logic first_give;
	logic index_set;
	logic index_step;

	assign take = cmd_valid && cmd_ready;
	assign give = rsp_valid && rsp_ready;
	assign cmd_ready = (state_reg != ATR_S_REPLY);
	assign rsp_valid = (state_reg == ATR_S_REPLY);
	assign last_rsp = rsp_second_reg && give;
	assign remain_dec = remain_reg - ATR_LEN_ONE;
	assign index_inc = index_reg + ATR_IDX_STEP;
	assign is_write_code = (cmd_byte == ATR_CMD_WRITE);
	assign is_read_code = (cmd_byte == ATR_CMD_READ);
	assign len_ok = (cmd_byte == ATR_LEN_THREE) || (cmd_byte == ATR_LEN_FOUR);
	assign addr_ok = is_write_reg ? (cmd_byte == ATR_ADDR_WRITE) : (cmd_byte == ATR_ADDR_READ);
	assign flag_ok = is_write_reg ?
		((cmd_byte == ATR_FLAG_KEEP) || (cmd_byte == ATR_FLAG_INC)) : (cmd_byte == ATR_READ_P1);
	// Data byte write only in a fully valid four-byte write frame
	assign data_write = take && (state_reg == ATR_S_DATA) && is_write_reg && frame_ok_reg;
	assign wr_reader = data_write && (index_reg == ATR_IDX_READER);
	assign wr_card = data_write && (index_reg == ATR_IDX_CARD);
	assign indexed_value = (index_reg == ATR_IDX_READER) ? reader_analog_tuning :
		(index_reg == ATR_IDX_CARD) ? card_emulation_analog_tuning : ATR_ZERO;
	assign reader_def = (protocol_code == ATR_PROT_TYPE_A) ? ATR_DEF_TYPE_A :
		(protocol_code == ATR_PROT_TYPE_B) ? ATR_DEF_TYPE_B :
		(protocol_code == ATR_PROT_18092) ? ATR_DEF_18092 :
		(protocol_code == ATR_PROT_VIC_30) ? ATR_DEF_VIC_30 : ATR_DEF_VIC_100;
	assign load_reader = protocol_choose_command && (protocol_code <= ATR_PROT_VIC_100);
	assign load_card = protocol_choose_command && (protocol_code == ATR_PROT_CE_A);
	// Frame length as offered now, before it is captured
	assign len_now = (state_reg == ATR_S_LEN) ? cmd_byte : len_reg;
	assign len_bad = (len_now != ATR_LEN_THREE) && (len_now != ATR_LEN_FOUR);
	assign bad_len_write = is_write_reg && len_bad;
	assign code_ok = is_write_code || is_read_code;
	assign read_tail_ok = is_write_reg || (cmd_byte == ATR_READ_P2);
	assign frame_ok_now = ((state_reg == ATR_S_CODE) || frame_ok_reg) && byte_ok;
	// Events on the two handshakes
	assign reply_start = take && (state_next == ATR_S_REPLY);
	assign first_give = give && !rsp_second_reg;
	// Index moves
	assign index_set = take && (state_reg == ATR_S_INDEX) && is_write_reg && frame_ok_reg;
	assign index_step = data_write && inc_reg;

	// Check of the byte now offered against the frame so far
	always_comb
	begin
		byte_ok = 1'b1;
		unique case (state_reg)
			ATR_S_CODE:
				byte_ok = code_ok;
			ATR_S_LEN:
				byte_ok = len_ok;
			ATR_S_ADDR:
				byte_ok = addr_ok;
			ATR_S_FLAG:
				byte_ok = flag_ok;
			ATR_S_INDEX:
				byte_ok = read_tail_ok;
			ATR_S_DATA:
				byte_ok = 1'b1;
			ATR_S_SKIP:
				byte_ok = 1'b1;
			ATR_S_REPLY:
				byte_ok = 1'b1;
			default:
				byte_ok = 1'b1;
		endcase
	end

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ATR_S_CODE:
				if (take)
					state_next = ATR_S_LEN;
			ATR_S_LEN:
				if (take)
					state_next = (cmd_byte == ATR_LEN_NONE) ? ATR_S_REPLY : ATR_S_ADDR;
			ATR_S_ADDR:
				if (take)
					state_next = (remain_reg == ATR_LEN_ONE) ? ATR_S_REPLY : ATR_S_FLAG;
			ATR_S_FLAG:
				if (take)
					state_next = (remain_reg == ATR_LEN_ONE) ? ATR_S_REPLY : ATR_S_INDEX;
			ATR_S_INDEX:
				if (take)
					state_next = (remain_reg == ATR_LEN_ONE) ? ATR_S_REPLY : ATR_S_DATA;
			ATR_S_DATA:
				if (take)
					state_next = (remain_reg == ATR_LEN_ONE) ? ATR_S_REPLY : ATR_S_SKIP;
			ATR_S_SKIP:
				if (take && (remain_reg == ATR_LEN_ONE))
					state_next = ATR_S_REPLY;
			ATR_S_REPLY:
				if (last_rsp)
					state_next = ATR_S_CODE;
			default:
				state_next = ATR_S_CODE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			state_reg <= ATR_S_CODE;
		else
			state_reg <= state_next;
	end

	// Frame header capture and remaining byte count
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			is_write_reg <= 1'b0;
			len_reg <= ATR_ZERO;
			remain_reg <= ATR_ZERO;
			frame_ok_reg <= 1'b0;
			inc_reg <= 1'b0;
		end
		else if (take)
		begin
			remain_reg <= (state_reg == ATR_S_LEN) ? cmd_byte : remain_dec;
			if (state_reg == ATR_S_CODE)
			begin
				is_write_reg <= is_write_code;
				frame_ok_reg <= is_write_code || is_read_code;
			end
			if (state_reg == ATR_S_LEN)
			begin
				len_reg <= cmd_byte;
				frame_ok_reg <= frame_ok_reg && len_ok;
			end
			if (state_reg == ATR_S_ADDR)
				frame_ok_reg <= frame_ok_reg && addr_ok;
			if (state_reg == ATR_S_FLAG)
			begin
				frame_ok_reg <= frame_ok_reg && flag_ok;
				inc_reg <= (cmd_byte == ATR_FLAG_INC);
			end
			if ((state_reg == ATR_S_INDEX) && !is_write_reg)
				frame_ok_reg <= frame_ok_reg && (cmd_byte == ATR_READ_P2);
		end
	end

	// Register index: set by index byte, advanced after a data write when the flag byte was ATR_FLAG_INC
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			index_reg <= ATR_ZERO;
		else if (index_set)
			index_reg <= cmd_byte;
		else if (index_step)
			index_reg <= index_inc;
	end

	// Reply bytes: the result byte goes out from a register, the second waits
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			rsp1_reg <= ATR_LEN_NONE;
			rsp_out_reg <= ATR_RES_OK;
		end
		else if (reply_start && !frame_ok_now)
		begin
			rsp_out_reg <= bad_len_write ? ATR_RES_BADLEN : ATR_RES_BADCMD;
			rsp1_reg <= ATR_LEN_NONE;
		end
		else if (reply_start && is_write_reg)
		begin
			rsp_out_reg <= ATR_RES_OK;
			rsp1_reg <= ATR_LEN_NONE;
		end
		else if (reply_start)
		begin
			rsp_out_reg <= ATR_RES_DATA;
			rsp1_reg <= indexed_value;
		end
		else if (first_give)
			rsp_out_reg <= rsp1_reg;
	end

	// Reply output byte stepping
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			rsp_second_reg <= 1'b0;
		else if (give)
			rsp_second_reg <= !rsp_second_reg;
	end
	assign rsp_byte = rsp_out_reg;

	atr_tune_reg u_reader_reg (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.load_default(load_reader),
		.default_value(reader_def),
		.write_en(wr_reader),
		.write_value(cmd_byte),
		.value(reader_analog_tuning)
	);

	atr_tune_reg u_card_reg (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.load_default(load_card),
		.default_value(ATR_DEF_CE_A),
		.write_en(wr_card),
		.write_value(cmd_byte & ATR_CARD_MASK),
		.value(card_emulation_analog_tuning)
	);

	atr_field_decode u_decode (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.reader_value(reader_analog_tuning),
		.card_value(card_emulation_analog_tuning),
		.modulation_pct(modulation_pct),
		.rx_gain_db(rx_gain_db),
		.demod_sens_pct(demod_sens_pct),
		.load_mod_index(load_mod_index)
	);
endmodule : atr_cmd_top

//--- design/atr_field_decode.sv
// Decodes the tuning registers into modulation, gain, sensitivity and load
`timescale 1ns/1ps
module atr_field_decode
	import atr_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reader_value,
	input wire logic [7:0] card_value,
	output logic [6:0] modulation_pct,
	output logic [5:0] rx_gain_db,
	output logic [6:0] demod_sens_pct,
	output logic [3:0] load_mod_index
);
	logic [3:0] mod_code;
	logic [3:0] gain_code;
	logic [1:0] sens_code;
	logic [6:0] mod_pct_next;
	logic [5:0] gain_next;
	logic [6:0] sens_next;
	logic [6:0] mod_pct_reg;
	logic [5:0] gain_reg;
	logic [6:0] sens_reg;
	logic [3:0] load_reg;

	assign mod_code = reader_value[ATR_MOD_HI:ATR_MOD_LO];
	assign gain_code = reader_value[ATR_GAIN_HI:ATR_GAIN_LO];
	assign sens_code = card_value[ATR_SENS_HI:ATR_SENS_LO];
	assign mod_pct_next = (mod_code == ATR_MC_10) ? ATR_PCT_10 :
		(mod_code == ATR_MC_17) ? ATR_PCT_17 :
		(mod_code == ATR_MC_25) ? ATR_PCT_25 :
		(mod_code == ATR_MC_30) ? ATR_PCT_30 :
		(mod_code == ATR_MC_33) ? ATR_PCT_33 :
		(mod_code == ATR_MC_36) ? ATR_PCT_36 :
		(mod_code == ATR_MC_95) ? ATR_PCT_95 : ATR_PCT_NONE;
	assign gain_next = (gain_code == ATR_GC_34) ? ATR_DB_34 :
		(gain_code == ATR_GC_32) ? ATR_DB_32 :
		(gain_code == ATR_GC_27) ? ATR_DB_27 :
		(gain_code == ATR_GC_20) ? ATR_DB_20 :
		(gain_code == ATR_GC_8) ? ATR_DB_8 : ATR_DB_NONE;
	assign sens_next = (sens_code == ATR_SENS_10) ? ATR_PCT_10 :
		(sens_code == ATR_SENS_100) ? ATR_PCT_100 : ATR_PCT_NONE;
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			mod_pct_reg <= ATR_PCT_NONE;
			gain_reg <= ATR_DB_NONE;
			sens_reg <= ATR_PCT_NONE;
			load_reg <= ATR_ZERO[ATR_LOAD_HI:ATR_LOAD_LO];
		end
		else
		begin
			mod_pct_reg <= mod_pct_next;
			gain_reg <= gain_next;
			sens_reg <= sens_next;
			load_reg <= card_value[ATR_LOAD_HI:ATR_LOAD_LO];
		end
	end
	assign modulation_pct = mod_pct_reg;
	assign rx_gain_db = gain_reg;
	assign demod_sens_pct = sens_reg;
	assign load_mod_index = load_reg;
endmodule : atr_field_decode

//--- design/atr_pkg.sv
// Package with command codes, register indices, defaults and decode tables
package atr_pkg;
	localparam logic [7:0] ATR_CMD_READ = 8'h08;
	localparam logic [7:0] ATR_CMD_WRITE = 8'h09;
	localparam logic [7:0] ATR_LEN_THREE = 8'h03;
	localparam logic [7:0] ATR_LEN_FOUR = 8'h04;
	localparam logic [7:0] ATR_ADDR_WRITE = 8'h68;
	localparam logic [7:0] ATR_ADDR_READ = 8'h69;
	localparam logic [7:0] ATR_READ_P1 = 8'h01;
	localparam logic [7:0] ATR_READ_P2 = 8'h00;
	localparam logic [7:0] ATR_FLAG_KEEP = 8'h00;
	localparam logic [7:0] ATR_FLAG_INC = 8'h01;
	localparam logic [7:0] ATR_IDX_READER = 8'h01;
	localparam logic [7:0] ATR_IDX_CARD = 8'h04;
	localparam logic [7:0] ATR_IDX_STEP = 8'h01;
	localparam logic [7:0] ATR_RES_OK = 8'h00;
	localparam logic [7:0] ATR_RES_DATA = 8'h01;
	localparam logic [7:0] ATR_RES_BADLEN = 8'h82;
	localparam logic [7:0] ATR_RES_BADCMD = 8'h83;
	localparam logic [7:0] ATR_LEN_NONE = 8'h00;
	localparam logic [7:0] ATR_LEN_ONE = 8'h01;
	localparam logic [7:0] ATR_ZERO = 8'h00;
	localparam logic [7:0] ATR_CARD_MASK = 8'h3F;
	// Protocol codes seen on the protocol choice input
	localparam logic [2:0] ATR_PROT_TYPE_A = 3'h0;
	localparam logic [2:0] ATR_PROT_TYPE_B = 3'h1;
	localparam logic [2:0] ATR_PROT_18092 = 3'h2;
	localparam logic [2:0] ATR_PROT_VIC_30 = 3'h3;
	localparam logic [2:0] ATR_PROT_VIC_100 = 3'h4;
	localparam logic [2:0] ATR_PROT_CE_A = 3'h5;
	localparam logic [7:0] ATR_DEF_TYPE_A = 8'hDF;
	localparam logic [7:0] ATR_DEF_TYPE_B = 8'h2F;
	localparam logic [7:0] ATR_DEF_18092 = 8'h5F;
	localparam logic [7:0] ATR_DEF_VIC_30 = 8'h53;
	localparam logic [7:0] ATR_DEF_VIC_100 = 8'hD3;
	localparam logic [7:0] ATR_DEF_CE_A = 8'h27;
	// Field positions
	localparam int ATR_MOD_HI = 7;
	localparam int ATR_MOD_LO = 4;
	localparam int ATR_GAIN_HI = 3;
	localparam int ATR_GAIN_LO = 0;
	localparam int ATR_SENS_HI = 5;
	localparam int ATR_SENS_LO = 4;
	localparam int ATR_LOAD_HI = 3;
	localparam int ATR_LOAD_LO = 0;
	// Modulation index codes and percent
	localparam logic [3:0] ATR_MC_10 = 4'h1;
	localparam logic [3:0] ATR_MC_17 = 4'h2;
	localparam logic [3:0] ATR_MC_25 = 4'h3;
	localparam logic [3:0] ATR_MC_30 = 4'h4;
	localparam logic [3:0] ATR_MC_33 = 4'h5;
	localparam logic [3:0] ATR_MC_36 = 4'h6;
	localparam logic [3:0] ATR_MC_95 = 4'hD;
	localparam logic [6:0] ATR_PCT_10 = 7'h0A;
	localparam logic [6:0] ATR_PCT_17 = 7'h11;
	localparam logic [6:0] ATR_PCT_25 = 7'h19;
	localparam logic [6:0] ATR_PCT_30 = 7'h1E;
	localparam logic [6:0] ATR_PCT_33 = 7'h21;
	localparam logic [6:0] ATR_PCT_36 = 7'h24;
	localparam logic [6:0] ATR_PCT_95 = 7'h5F;
	localparam logic [6:0] ATR_PCT_100 = 7'h64;
	localparam logic [6:0] ATR_PCT_NONE = 7'h00;
	// Receiver gain codes and decibels
	localparam logic [3:0] ATR_GC_34 = 4'h0;
	localparam logic [3:0] ATR_GC_32 = 4'h1;
	localparam logic [3:0] ATR_GC_27 = 4'h3;
	localparam logic [3:0] ATR_GC_20 = 4'h7;
	localparam logic [3:0] ATR_GC_8 = 4'hF;
	localparam logic [5:0] ATR_DB_34 = 6'h22;
	localparam logic [5:0] ATR_DB_32 = 6'h20;
	localparam logic [5:0] ATR_DB_27 = 6'h1B;
	localparam logic [5:0] ATR_DB_20 = 6'h14;
	localparam logic [5:0] ATR_DB_8 = 6'h08;
	localparam logic [5:0] ATR_DB_NONE = 6'h00;
	localparam logic [1:0] ATR_SENS_10 = 2'h1;
	localparam logic [1:0] ATR_SENS_100 = 2'h2;
	localparam logic [3:0] ATR_LOAD_MIN = 4'h1;
	localparam logic [3:0] ATR_LOAD_DEF = 4'h7;
	localparam logic [3:0] ATR_LOAD_MAX = 4'hF;
	typedef enum logic [7:0] {
		ATR_S_CODE = 8'h01,
		ATR_S_LEN = 8'h02,
		ATR_S_ADDR = 8'h04,
		ATR_S_FLAG = 8'h08,
		ATR_S_INDEX = 8'h10,
		ATR_S_DATA = 8'h20,
		ATR_S_SKIP = 8'h40,
		ATR_S_REPLY = 8'h80
	} atr_state_e;
endpackage : atr_pkg

//--- design/atr_tune_reg.sv
// One 8-bit tuning register with protocol default load and host write
`timescale 1ns/1ps
module atr_tune_reg
	import atr_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic load_default,
	input wire logic [7:0] default_value,
	input wire logic write_en,
	input wire logic [7:0] write_value,
	output logic [7:0] value
);
	logic [7:0] value_reg;
	logic [7:0] value_next;

	// Protocol default and host write both overwrite; write wins in the same cycle
	assign value_next = write_en ? write_value : (load_default ? default_value : value_reg);
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			value_reg <= ATR_ZERO;
		else
			value_reg <= value_next;
	end
	assign value = value_reg;
endmodule : atr_tune_reg

//--- verification/atr_cmd_sva.sv
// Checker for the analog tuning command interpreter
`timescale 1ns/1ps
module atr_cmd_sva
	import atr_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_byte,
	input wire logic rsp_ready,
	input wire logic protocol_choose_command,
	input wire logic [2:0] protocol_code,
	input wire logic [7:0] reader_analog_tuning,
	input wire logic [7:0] card_emulation_analog_tuning,
	input wire logic [6:0] modulation_pct,
	input wire logic [5:0] rx_gain_db,
	input wire logic [6:0] demod_sens_pct,
	input wire logic [3:0] load_mod_index
);
	localparam logic [6:0] MP [16] = '{7'h00, 7'h0A, 7'h11, 7'h19, 7'h1E, 7'h21, 7'h24, 7'h00,
		7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h5F, 7'h00, 7'h00};
	localparam logic [5:0] GD [16] = '{6'h22, 6'h20, 6'h00, 6'h1B, 6'h00, 6'h00, 6'h00, 6'h14,
		6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h08};
	localparam logic [6:0] SP [4] = '{7'h00, 7'h0A, 7'h64, 7'h00};
	localparam logic [7:0] RD [5] = '{8'hDF, 8'h2F, 8'h5F, 8'h53, 8'hD3};
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire take = cmd_valid && cmd_ready;
	sequence s_card_write;
		take && cmd_byte == ATR_CMD_WRITE ##1 take && cmd_byte == ATR_LEN_FOUR
		##1 take && cmd_byte == ATR_ADDR_WRITE ##1 take
		##1 take && cmd_byte == ATR_IDX_CARD ##1 take;
	endsequence
	sequence s_read;
		take && cmd_byte == ATR_CMD_READ ##1 take && cmd_byte == ATR_LEN_THREE
		##1 take && cmd_byte == ATR_ADDR_READ ##1 take && cmd_byte == ATR_READ_P1
		##1 take && cmd_byte == ATR_READ_P2;
	endsequence
	property p_card_write;
		s_card_write |=> card_emulation_analog_tuning == ($past(cmd_byte) & ATR_CARD_MASK);
	endproperty
	property p_write_ok;
		s_card_write |=> rsp_valid && !cmd_ready && rsp_byte == ATR_RES_OK;
	endproperty
	property p_ok_len;
		s_card_write ##1 (rsp_valid && rsp_ready) |=> rsp_valid && rsp_byte == ATR_LEN_NONE;
	endproperty
	property p_read;
		s_read |=> rsp_valid && rsp_byte == ATR_RES_DATA;
	endproperty
	property p_proto_rdr;
		protocol_choose_command && !take && protocol_code < 3'h5
		|=> reader_analog_tuning == RD[$past(protocol_code)];
	endproperty
	property p_proto_card;
		protocol_choose_command && !take && protocol_code == ATR_PROT_CE_A
		|=> card_emulation_analog_tuning == ATR_DEF_CE_A;
	endproperty
	property p_hold;
		!protocol_choose_command && !take
		|=> $stable(reader_analog_tuning) && $stable(card_emulation_analog_tuning);
	endproperty
	property p_reserved;
		card_emulation_analog_tuning[7:6] == 2'h0;
	endproperty
	property p_rdr_dec;
		!$past(sys_rst) |-> modulation_pct == MP[$past(reader_analog_tuning[7:4])]
		&& rx_gain_db == GD[$past(reader_analog_tuning[3:0])];
	endproperty
	property p_card_dec;
		!$past(sys_rst) |-> load_mod_index == $past(card_emulation_analog_tuning[3:0])
		&& demod_sens_pct == SP[$past(card_emulation_analog_tuning[5:4])];
	endproperty
	a_card_write: assert property (p_card_write) else $error("card write lost");
	a_write_ok: assert property (p_write_ok) else $error("bad write result");
	a_ok_len: assert property (p_ok_len) else $error("bad write length");
	a_read: assert property (p_read) else $error("bad read result");
	a_proto_rdr: assert property (p_proto_rdr) else $error("reader default");
	a_proto_card: assert property (p_proto_card) else $error("card default");
	a_hold: assert property (p_hold) else $error("register changed");
	a_reserved: assert property (p_reserved) else $error("reserved bits set");
	a_rdr_dec: assert property (p_rdr_dec) else $error("reader decode");
	a_card_dec: assert property (p_card_dec) else $error("card decode");
endmodule : atr_cmd_sva

bind atr_cmd_top atr_cmd_sva i_atr_cmd_sva (.*);

//--- verification/atr_host_model.sv
// Host model that frames commands and takes two-byte replies with random stalls
`timescale 1ns/1ps
module atr_host_model
	import atr_pkg::*;
(
	input wire logic core_clk,
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_byte,
	output logic rsp_ready
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
		rsp_ready = 1'b0;
	end
	task automatic xfer(input logic [47:0] f, input int n, output logic [15:0] r);
		int i;
		for (i = 0; i < n; i++)
		begin
			@(negedge core_clk);
			cmd_valid = 1'b1;
			cmd_byte = f[8 * (n - 1 - i) +: 8];
			while (!cmd_ready)
				@(negedge core_clk);
			@(posedge core_clk);
		end
		r = 16'h0000;
		for (i = 0; i < 2; i++)
		begin
			do
			begin
				@(negedge core_clk);
				cmd_valid = 1'b0;
				cmd_byte = ~cmd_byte;
				rsp_ready = ($urandom_range(3) != 0);
			end
			while (!(rsp_valid && rsp_ready));
			r = {r[7:0], rsp_byte};
			@(posedge core_clk);
		end
		@(negedge core_clk);
		rsp_ready = 1'b0;
	endtask : xfer
endmodule : atr_host_model

//--- verification/testbench.sv
// Self-checking testbench for the analog tuning command interpreter
`timescale 1ns/1ps
module testbench;
	import atr_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic protocol_choose_command = 1'b0;
	logic [2:0] protocol_code = 3'h0;
	logic cmd_valid, cmd_ready, rsp_valid, rsp_ready;
	logic [7:0] cmd_byte, rsp_byte, reader_analog_tuning, card_emulation_analog_tuning, v;
	logic [6:0] modulation_pct, demod_sens_pct;
	logic [5:0] rx_gain_db;
	logic [3:0] load_mod_index;
	logic [15:0] r;
	int fails = 0;
	int n_checks = 0;
	localparam logic [3:0] MC [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hD};
	localparam logic [6:0] MP [7] = '{7'h0A, 7'h11, 7'h19, 7'h1E, 7'h21, 7'h24, 7'h5F};
	localparam logic [3:0] GC [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
	localparam logic [5:0] GD [5] = '{6'h22, 6'h20, 6'h1B, 6'h14, 6'h08};
	localparam logic [7:0] RD [5] = '{8'hDF, 8'h2F, 8'h5F, 8'h53, 8'hD3};
	always #2.5 core_clk = ~core_clk;
	atr_cmd_top i_atr_cmd_top (.*);
	atr_host_model i_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_ready(rsp_ready));
	function automatic logic [6:0] sens_pct(input logic [7:0] x);
		return (x[5:4] == 2'h1) ? 7'h0A : 7'h64;
	endfunction : sens_pct
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	task automatic choose(input logic [2:0] c);
		@(negedge core_clk);
		protocol_choose_command = 1'b1;
		protocol_code = c;
		@(negedge core_clk);
		protocol_choose_command = 1'b0;
		protocol_code = 3'($urandom);
	endtask : choose
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		i_host.xfer({16'h0009, 24'h036800, idx}, 5, r);
		check(r, 16'h0000);
		i_host.xfer(48'h0803690100, 5, r);
		check(r, {8'h01, exp});
	endtask : rd
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fails++;
		conclude();
	end
	initial
	begin
		void'($urandom(32'hFE81));
		repeat (16) @(negedge core_clk);
		sys_rst = 1'b0;
		for (int c = 0; c < 5; c++)
		begin
			choose(3'(c));
			check(16'(reader_analog_tuning), 16'(RD[c]));
			rd(8'h01, RD[c]);
		end
		choose(ATR_PROT_CE_A);
		rd(8'h04, 8'h27);
		check(16'(load_mod_index), 16'h0007);
		for (int k = 0; k < 6; k++)
		begin
			v = (k == 0) ? 8'h11 : (k == 1) ? 8'h2F : {2'h0, 2'(k % 2 + 1), 4'($urandom)};
			i_host.xfer({8'h09, 8'h04, 8'h68, 8'h00, 8'h04, v}, 6, r);
			check(r, 16'h0000);
			check(16'(card_emulation_analog_tuning), 16'(v));
			check(16'(demod_sens_pct), 16'(sens_pct(v)));
			check(16'(load_mod_index), 16'(v[3:0]));
			i_host.xfer(48'h0803690100, 5, r);
			check(r, {8'h01, v});
		end
		choose(ATR_PROT_CE_A);
		check(16'(card_emulation_analog_tuning), 16'h0027);
		for (int i = 0; i < 7; i++)
		begin
			v = {MC[i], GC[i % 5]};
			choose((i < 4) ? ATR_PROT_TYPE_B : (i < 6) ? ATR_PROT_VIC_30 : ATR_PROT_TYPE_A);
			i_host.xfer({8'h09, 8'h04, 8'h68, 8'h01, 8'h01, v}, 6, r);
			check(r, 16'h0000);
			i_host.xfer(48'h0803690100, 5, r);
			check(r, 16'h0100);
			check(16'(modulation_pct), 16'(MP[i]));
			check(16'(rx_gain_db), 16'(GD[i % 5]));
			rd(8'h01, v);
		end
		for (int n = 0; n < 3; n++)
		begin
			i_host.xfer(48'({8'h09, 8'(n), 8'h68, 8'h00} >> (8 * (2 - n))), n + 2, r);
			check(r, 16'h8200);
			check({reader_analog_tuning, card_emulation_analog_tuning}, {v, 8'h27});
		end
		@(negedge core_clk);
		sys_rst = 1'b1;
		repeat (2) @(negedge core_clk);
		sys_rst = 1'b0;
		check({reader_analog_tuning, card_emulation_analog_tuning}, 16'h0000);
		rd(8'h01, 8'h00);
		conclude();
	end
endmodule : testbench
